// File: common/ovrd_pkg.sv
// overrange detector package: register map, field layout, reset values,
// timing counts, link modes and the packed carriers shared by the design.
// assumes a 32-bit apb register bus and 12-bit two's complement samples.
package ovrd_pkg;

	// ----------------------------------------------------------------
	// data widths
	// ----------------------------------------------------------------
	localparam int SAMPLE_W   = 12;  // converter sample width
	localparam int CMP_W      = 8;   // magnitude bits compared
	localparam int DEC_W      = 16;  // decimated output word width
	localparam int NFLAG      = 4;   // two thresholds on two channels
	localparam int SEL_W      = 3;   // flag_hold_length_select width
	localparam int HOLD_CNT_W = 11;  // holds up to 1024 cycles
	localparam int WIN_CNT_W  = 9;   // holds up to 256 samples
	localparam int HOLD_BASE  = 8;   // hold length at select 0, cycles

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL       = 12'h000;
	localparam logic [11:0] OFS_STATUS     = 12'h004;
	localparam logic [11:0] OFS_INT_STATUS = 12'h008;
	localparam logic [11:0] OFS_INT_MASK   = 12'h00C;

	// control register field positions
	localparam int CTRL_THR_HI_LSB = 0;
	localparam int CTRL_THR_LO_LSB = 8;
	localparam int CTRL_HOLD_LSB   = 16;
	localparam int CTRL_MODE_LSB   = 20;
	localparam int CTRL_SINGLE_BIT = 24;
	localparam int CTRL_FGCAL_BIT  = 25;
	localparam int CTRL_BGCAL_BIT  = 26;
	localparam logic [31:0] CTRL_WMASK = 32'h0737_FFFF;

	// status register field positions
	localparam int STAT_LIVE_LSB = 0;
	localparam int STAT_EMB_LSB  = 4;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_FFFF;
	localparam logic [3:0]  MASK_RST = 4'h0;

	// flag vector index
	localparam int FLG_A_HI = 0;
	localparam int FLG_A_LO = 1;
	localparam int FLG_B_HI = 2;
	localparam int FLG_B_LO = 3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OVRD_EMB_OFF,
		OVRD_EMB_COMPLEX,
		OVRD_EMB_REAL,
		OVRD_EMB_RSVD
	} ovrd_link_mode_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] b;
		logic [SAMPLE_W-1:0] a;
	} ovrd_samples_t;

	typedef struct packed {
		logic [DEC_W-1:0] b;
		logic [DEC_W-1:0] a;
	} ovrd_dec_t;

	typedef struct packed {
		logic b_low;
		logic b_high;
		logic a_low;
		logic a_high;
	} ovrd_flags_t;

endpackage

// File: rtl/ovrd_stretch.sv
// overrange detector: one flag pulse stretcher.
// assumes hit and hold_len are synchronous to pclk; hold_len is at least 1.
`timescale 1ns/10ps
`default_nettype none

module ovrd_stretch #(
	parameter int HOLD_CNT_W = 11
) (
	input  wire logic                  pclk,     // device clock
	input  wire logic                  presetn,  // async reset, active low
	input  wire logic                  ce,       // clock enable
	input  wire logic                  hit,      // overrange seen this cycle
	input  wire logic [HOLD_CNT_W-1:0] hold_len, // pulse length in cycles
	output logic                       flag      // stretched flag
);

	logic [HOLD_CNT_W-1:0] cnt_q;
	logic [HOLD_CNT_W-1:0] cnt_d;
	logic                  flag_q;
	logic                  flag_d;

	// --------------------------------------------------------------
	// hold counter
	// --------------------------------------------------------------
	// reload on every hit, count down after the last one
	always_comb begin
		cnt_d  = cnt_q;
		flag_d = 1'b0;
		if (hit) begin
			cnt_d  = HOLD_CNT_W'(hold_len - 1'b1);
			flag_d = 1'b1;
		end else if (cnt_q != '0) begin
			cnt_d  = HOLD_CNT_W'(cnt_q - 1'b1);
			flag_d = 1'b1;
		end
	end

	// register the counter and the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= '0;
			flag_q <= 1'b0;
		end else if (ce) begin
			cnt_q  <= cnt_d;
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;

endmodule

`default_nettype wire

// File: rtl/ovrd_top.sv
// overrange detector top: magnitude compare, flag stretch, embedding, apb regs.
// assumes all inputs synchronous to pclk and an apb master on the bus.
//
// Overview of operation
// - each 12-bit sample: take magnitude, compare its upper 8 bits to two thresholds
// - flag is 1 if magnitude reached its threshold within the period, else 0
// - both channels use the same two threshold settings
// - most negative sample saturates to 2047, upper bits 255
// - each channel drives a high-threshold flag and a low-threshold flag
// - flag stays set 8 times two to the select cycles after last event
// - flags embedded in output words only in decimating one-control-bit modes
// - complex: in-phase lsb carries high flag, quadrature lsb carries low flag
// - real: even samples carry high flag, odd samples carry low flag
// - embedding window is 2^select samples complex, twice that real
// - codes are signed two's complement, sign follows input polarity
// - dual takes one sample per edge, single takes two per clock
// - foreground calibration stops sampling, background keeps converting
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module ovrd_top #(
	parameter int HOLD_BASE = ovrd_pkg::HOLD_BASE
) (
	input  wire logic                  pclk,          // device clock
	input  wire logic                  presetn,       // async reset, active low
	input  wire logic                  ce,            // clock enable
	input  wire logic [11:0]           paddr,         // apb address
	input  wire logic                  psel,          // apb select
	input  wire logic                  penable,       // apb enable
	input  wire logic                  pwrite,        // apb direction
	input  wire logic [31:0]           pwdata,        // apb write data
	input  wire logic [3:0]            pstrb,         // apb byte strobes
	output logic [31:0]                prdata,        // apb read data
	output logic                       pready,        // apb ready
	output logic                       pslverr,       // apb error
	input  wire logic                  samp_valid,    // converter samples valid
	input  wire ovrd_pkg::ovrd_samples_t samp,        // channel a and b samples
	input  wire logic                  dec_valid,     // decimated words valid
	input  wire logic                  dec_iq,        // 0 in-phase, 1 quadrature
	input  wire ovrd_pkg::ovrd_dec_t   dec_in,        // decimated words in
	output logic                       dec_out_valid, // words out valid
	output ovrd_pkg::ovrd_dec_t        dec_out,       // words with embedded flags
	output ovrd_pkg::ovrd_flags_t      ovr_flags,     // stretched flag outputs
	output logic                       irq            // level interrupt
);

	import ovrd_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (HOLD_BASE < 1 || (HOLD_BASE << 7) >= (1 << HOLD_CNT_W)) begin : g_chk
		$error("hold base does not fit the hold counter");
	end

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [31:0]      ctrl_q;
	logic [31:0]      ctrl_d;
	logic [NFLAG-1:0] int_stat_q;
	logic [NFLAG-1:0] int_stat_d;
	logic [NFLAG-1:0] int_mask_q;
	logic [NFLAG-1:0] int_mask_d;
	logic [NFLAG-1:0] flag_prev_q;
	logic             irq_q;
	logic             irq_d;
	logic             pready_q;
	logic             pready_d;
	logic             pslverr_q;
	logic             pslverr_d;
	logic [31:0]      prdata_q;
	logic [31:0]      prdata_d;

	// decoded control fields
	logic [CMP_W-1:0]   thr_hi;
	logic [CMP_W-1:0]   thr_lo;
	logic [SEL_W-1:0]   hold_sel;
	ovrd_link_mode_t    link_mode_select;
	logic               single_chan;
	logic               fg_cal;
	logic               emb_on;

	assign thr_hi           = ctrl_q[CTRL_THR_HI_LSB +: CMP_W];
	assign thr_lo           = ctrl_q[CTRL_THR_LO_LSB +: CMP_W];
	assign hold_sel         = ctrl_q[CTRL_HOLD_LSB +: SEL_W];
	assign link_mode_select = ovrd_link_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
	assign single_chan      = ctrl_q[CTRL_SINGLE_BIT];
	assign fg_cal           = ctrl_q[CTRL_FGCAL_BIT];
	// embedding only in dual-channel decimating modes
	assign emb_on           = !single_chan && (link_mode_select == OVRD_EMB_COMPLEX ||
	                          link_mode_select == OVRD_EMB_REAL);

	// ----------------------------------------------------------------
	// magnitude compare
	// ----------------------------------------------------------------
	// saturating magnitude, upper bits below the sign
	function automatic logic [CMP_W-1:0] mag_top(input logic [SAMPLE_W-1:0] s);
		logic [SAMPLE_W-1:0] m;
		m = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
		if (s == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
			m = {1'b0, {(SAMPLE_W-1){1'b1}}};
		end
		return m[SAMPLE_W-2 -: CMP_W];
	endfunction

	logic                  samp_ok;
	logic [NFLAG-1:0]      hit;
	logic [NFLAG-1:0]      flag_w;
	logic [HOLD_CNT_W-1:0] hold_len;

	// foreground calibration takes the converter offline
	assign samp_ok  = samp_valid && !fg_cal;
	assign hold_len = HOLD_CNT_W'(HOLD_BASE) << hold_sel;

	// one compare pair and two stretchers per channel; in single-channel
	// use lane a and lane b carry the two samples of each clock
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic [CMP_W-1:0] mag;
		assign mag = mag_top(ch == 0 ? samp.a : samp.b);
		assign hit[2*ch]   = samp_ok && (mag >= thr_hi);
		assign hit[2*ch+1] = samp_ok && (mag >= thr_lo);
		for (genvar t = 0; t < 2; t++) begin : g_thr
			ovrd_stretch #(
				.HOLD_CNT_W (HOLD_CNT_W)
			) u_stretch (
				.pclk     (pclk),
				.presetn  (presetn),
				.ce       (ce),
				.hit      (hit[2*ch+t]),
				.hold_len (hold_len),
				.flag     (flag_w[2*ch+t])
			);
		end
	end

	// flag vector maps onto the named outputs
	assign ovr_flags = ovrd_flags_t'(flag_w);

	// ----------------------------------------------------------------
	// embedding window
	// ----------------------------------------------------------------
	logic [WIN_CNT_W-1:0] win_cnt_q;
	logic [WIN_CNT_W-1:0] win_cnt_d;
	logic [WIN_CNT_W-1:0] win_last;
	logic [NFLAG-1:0]     win_acc_q;
	logic [NFLAG-1:0]     win_acc_d;
	logic [NFLAG-1:0]     emb_q;
	logic [NFLAG-1:0]     emb_d;
	logic                 parity_q;
	logic                 parity_d;
	ovrd_dec_t            dec_q;
	ovrd_dec_t            dec_d;
	logic                 dec_v_q;
	logic                 dec_v_d;

	// last count of the window, real mode doubles the window length
	assign win_last = (link_mode_select == OVRD_EMB_REAL) ?
	                  WIN_CNT_W'((2 << hold_sel) - 1) :
	                  WIN_CNT_W'((1 << hold_sel) - 1);

	// gather hits over a window, publish at its end
	always_comb begin
		win_cnt_d = win_cnt_q;
		win_acc_d = win_acc_q;
		emb_d     = emb_q;
		if (!emb_on) begin
			win_cnt_d = '0;
			win_acc_d = '0;
			emb_d     = '0;
		end else if (samp_ok) begin
			if (win_cnt_q >= win_last) begin
				emb_d     = win_acc_q | hit;
				win_acc_d = '0;
				win_cnt_d = '0;
			end else begin
				win_acc_d = win_acc_q | hit;
				win_cnt_d = WIN_CNT_W'(win_cnt_q + 1'b1);
			end
		end
	end

	// pick the lsb of each outgoing word
	always_comb begin
		parity_d = parity_q;
		dec_d    = dec_q;
		dec_v_d  = dec_valid && !fg_cal;
		if (dec_valid && !fg_cal) begin
			dec_d = dec_in;
			if (emb_on && link_mode_select == OVRD_EMB_COMPLEX) begin
				dec_d.a[0] = dec_iq ? emb_q[FLG_A_LO] : emb_q[FLG_A_HI];
				dec_d.b[0] = dec_iq ? emb_q[FLG_B_LO] : emb_q[FLG_B_HI];
			end else if (emb_on) begin
				dec_d.a[0] = parity_q ? emb_q[FLG_A_LO] : emb_q[FLG_A_HI];
				dec_d.b[0] = parity_q ? emb_q[FLG_B_LO] : emb_q[FLG_B_HI];
			end
			parity_d = emb_on && (link_mode_select == OVRD_EMB_REAL) && !parity_q;
		end
		if (!emb_on) begin
			parity_d = 1'b0;
		end
	end

	// register window and output path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt_q <= '0;
			win_acc_q <= '0;
			emb_q     <= '0;
			parity_q  <= 1'b0;
			dec_q     <= '0;
			dec_v_q   <= 1'b0;
		end else if (ce) begin
			win_cnt_q <= win_cnt_d;
			win_acc_q <= win_acc_d;
			emb_q     <= emb_d;
			parity_q  <= parity_d;
			dec_q     <= dec_d;
			dec_v_q   <= dec_v_d;
		end
	end

	assign dec_out       = dec_q;
	assign dec_out_valid = dec_v_q;

	// ----------------------------------------------------------------
	// apb slave and registers
	// ----------------------------------------------------------------
	logic        acc;
	logic        commit;
	logic        mapped;
	logic [31:0] rd_mux;
	logic [31:0] bmask;
	logic [NFLAG-1:0] rise;

	// byte strobes widened to bit mask
	for (genvar b = 0; b < 4; b++) begin : g_strb
		assign bmask[8*b +: 8] = {8{pstrb[b]}};
	end

	assign acc    = psel && penable;
	assign commit = acc && pready_q && pwrite && mapped;
	assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
	                (paddr == OFS_INT_STATUS) || (paddr == OFS_INT_MASK);
	assign rise   = flag_w & ~flag_prev_q;

	// read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			OFS_CTRL:       rd_mux = ctrl_q;
			OFS_STATUS: begin
				rd_mux[STAT_LIVE_LSB +: NFLAG] = flag_w;
				rd_mux[STAT_EMB_LSB +: NFLAG]  = emb_q;
			end
			OFS_INT_STATUS: rd_mux[NFLAG-1:0] = int_stat_q;
			OFS_INT_MASK:   rd_mux[NFLAG-1:0] = int_mask_q;
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	// bus handshake, register writes and sticky events
	always_comb begin
		pready_d   = acc && !pready_q;
		pslverr_d  = acc && !pready_q && !mapped;
		prdata_d   = (acc && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
		ctrl_d     = ctrl_q;
		int_mask_d = int_mask_q;
		int_stat_d = int_stat_q;
		if (commit && paddr == OFS_CTRL) begin
			ctrl_d = (ctrl_q & ~(bmask & CTRL_WMASK)) | (pwdata & bmask & CTRL_WMASK);
		end
		if (commit && paddr == OFS_INT_MASK && pstrb[0]) begin
			int_mask_d = pwdata[NFLAG-1:0];
		end
		if (commit && paddr == OFS_INT_STATUS && pstrb[0]) begin
			int_stat_d = int_stat_q & ~pwdata[NFLAG-1:0];
		end
		// set wins over a clear in the same cycle
		int_stat_d = int_stat_d | rise;
		irq_d      = |(int_stat_q & int_mask_q);
	end

	// register the bus and control state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= CTRL_RST;
			int_mask_q  <= MASK_RST;
			int_stat_q  <= '0;
			flag_prev_q <= '0;
			irq_q       <= 1'b0;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			prdata_q    <= 32'h0000_0000;
		end else if (ce) begin
			ctrl_q      <= ctrl_d;
			int_mask_q  <= int_mask_d;
			int_stat_q  <= int_stat_d;
			flag_prev_q <= flag_w;
			irq_q       <= irq_d;
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
			prdata_q    <= prdata_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;

endmodule

`default_nettype wire

// File: tb/ovrd_chk_chk.sv
// overrange detector checker: port-level assertions and covers.
// assumes binding into ovrd_top; follows the calibration bit from apb writes.
`timescale 1ns/10ps
`default_nettype none

module ovrd_chk #(
	parameter int HOLD_BASE = 8
) (
	input wire logic                    pclk,          // clock
	input wire logic                    presetn,       // reset
	input wire logic                    ce,            // enable
	input wire logic [11:0]             paddr,         // address
	input wire logic                    psel,          // select
	input wire logic                    penable,       // enable
	input wire logic                    pwrite,        // direction
	input wire logic [31:0]             pwdata,        // wdata
	input wire logic [3:0]              pstrb,         // strobes
	input wire logic [31:0]             prdata,        // rdata
	input wire logic                    pready,        // ready
	input wire logic                    pslverr,       // error
	input wire logic                    samp_valid,    // samples valid
	input wire ovrd_pkg::ovrd_samples_t samp,          // samples
	input wire logic                    dec_valid,     // words valid
	input wire logic                    dec_iq,        // word kind
	input wire ovrd_pkg::ovrd_dec_t     dec_in,        // words in
	input wire logic                    dec_out_valid, // words out valid
	input wire ovrd_pkg::ovrd_dec_t     dec_out,       // words out
	input wire ovrd_pkg::ovrd_flags_t   ovr_flags,     // flags
	input wire logic                    irq            // interrupt
);
	import ovrd_pkg::*;
	localparam int LMAX = HOLD_BASE * 128 + 2;
	logic        fg_d, fg_q;
	logic [10:0] idle_d, idle_q;
	wire logic   hit_a = samp_valid && ce && !fg_q && samp.a == 12'h800;
	wire logic   hit_b = samp_valid && ce && !fg_q && samp.b == 12'h800;

	// calibration bit and cycles since the last sample
	always_comb begin
		fg_d = fg_q;
		if (ce && psel && penable && pready && pwrite && paddr == OFS_CTRL && pstrb[3])
			fg_d = pwdata[CTRL_FGCAL_BIT];
		idle_d = (samp_valid || !ce) ? 11'h000 : idle_q + {10'h000, idle_q != 11'h7FF};
	end

	// helper registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fg_q   <= 1'b0;
			idle_q <= 11'h000;
		end else begin
			fg_q   <= fg_d;
			idle_q <= idle_d;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	hold_chan_a_a: assert property (hit_a |=> (ovr_flags.a_high && ovr_flags.a_low) [*8])
		else $error("channel a flags dropped early");
	hold_chan_b_a: assert property (hit_b |=> (ovr_flags.b_high && ovr_flags.b_low) [*8])
		else $error("channel b flags dropped early");
	cause_a_a: assert property ($rose(ovr_flags.a_high) |-> $past(samp_valid))
		else $error("channel a flag rose without a sample");
	cause_b_a: assert property ($rose(ovr_flags.b_low) |-> $past(samp_valid))
		else $error("channel b flag rose without a sample");
	flag_expiry_a: assert property (idle_q > LMAX |-> ovr_flags == 4'h0)
		else $error("flag held past the longest pulse");
	calib_halt_a: assert property (fg_q |=> !dec_out_valid && !$rose(ovr_flags != 4'h0))
		else $error("activity during foreground calibration");
	word_pass_a: assert property (dec_out_valid |-> $past(dec_valid) && dec_out.a[15:1] == $past(dec_in.a[15:1])
		&& dec_out.b[15:1] == $past(dec_in.b[15:1]))
		else $error("decimated word upper bits changed");
	one_wait_a: assert property (ce && psel && penable && !pready |=> pready)
		else $error("bus answer not after one wait");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");

	cover property (hit_a);
	cover property (fg_q && dec_valid);
	cover property (irq);
endmodule

bind ovrd_top ovrd_chk #(.HOLD_BASE(HOLD_BASE)) ovrd_chk_inst (.pclk, .presetn, .ce, .paddr, .psel,
	.penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .samp_valid, .samp, .dec_valid,
	.dec_iq, .dec_in, .dec_out_valid, .dec_out, .ovr_flags, .irq);
`default_nettype wire

// File: tb/ovrd_gain.sv
// downstream gain logic model: merges flags per threshold.
// assumes flags from ovrd_top and a mode bit set with the control word.
`timescale 1ns/10ps
`default_nettype none

module ovrd_gain (
	input  wire logic                  single,    // single-channel use
	input  wire ovrd_pkg::ovrd_flags_t flags,     // device flags
	output logic                       over_high, // first threshold tripped
	output logic                       over_low   // second threshold tripped
);
	import ovrd_pkg::*;
	// dual watches channel a, single ors both lanes
	always_comb begin
		over_high = flags.a_high || (single && flags.b_high);
		over_low  = flags.a_low || (single && flags.b_low);
	end
endmodule
`default_nettype wire

// File: tb/ovrd_top_test.sv
// overrange detector bench: apb tasks, sample and word drivers, checks.
// assumes ovrd_top with the default hold base and the gain model beside it.
`timescale 1ns/10ps
`default_nettype none

module ovrd_top_test;
	import ovrd_pkg::*;
	logic          pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err_v;
	logic          samp_valid, dec_valid, dec_iq, dec_out_valid, irq, single, over_high, over_low;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, rd_v;
	logic [3:0]    pstrb;
	ovrd_samples_t samp;
	ovrd_dec_t     dec_in, dec_out;
	ovrd_flags_t   ovr_flags;
	int            mismatches, comparisons, n;
	logic [11:0]   tv [4] = '{12'h200, 12'h1F8, 12'hE08, 12'h0FF};
	logic [3:0]    te [4] = '{4'hF, 4'hA, 4'hA, 4'h0};
	logic [1:0]    em [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
	logic          eq [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [31:0]   ew [6] = '{32'h5554_AAAA, 32'h5554_AAAB, 32'h5554_AAAA, 32'h5554_AAAB,
		32'h5555_AAAA, 32'h5555_AAAA};

	ovrd_top ovrd_top_inst (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .samp_valid, .samp, .dec_valid, .dec_iq, .dec_in, .dec_out_valid,
		.dec_out, .ovr_flags, .irq);
	ovrd_gain ovrd_gain_inst (.single, .flags(ovr_flags), .over_high, .over_low);

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			summarize();
		end
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] cw(input logic [7:0] hi, lo, input logic [2:0] sel,
		input logic [1:0] md, input logic sg, fg);
		return {6'h00, fg, sg, 2'h0, md, 1'b0, sel, lo, hi};
	endfunction

	task automatic setc(input logic [31:0] c);
		single <= c[CTRL_SINGLE_BIT];
		apb(1'b1, OFS_CTRL, c);
	endtask

	// one sample cycle on both lanes
	task automatic shot(input logic [11:0] a, input logic [11:0] b);
		@(posedge pclk);
		samp_valid <= 1'b1;
		samp <= {b, a};
		@(posedge pclk);
		samp_valid <= 1'b0;
		samp <= 24'h00_0000;
	endtask

	// one decimated word, checked the cycle after
	task automatic word(input logic iq, input logic [31:0] exp);
		@(posedge pclk);
		dec_valid <= 1'b1;
		dec_iq <= iq;
		@(posedge pclk);
		dec_valid <= 1'b0;
		#1;
		chk({dec_out_valid, dec_out}, {1'b1, exp});
	endtask

	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, samp_valid, dec_valid, dec_iq, single} = 8'h00;
		{paddr, pwdata, samp} = 68'h0;
		ce = 1'b1;
		pstrb = 4'hF;
		dec_in = 32'h5555_AAAA;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk(rd_v, CTRL_RST);
		apb(1'b0, OFS_INT_MASK, 32'h0000_0000);
		chk(rd_v, 32'h0000_0000);
		apb(1'b1, OFS_STATUS, 32'h0000_00FF);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd_v, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({err_v, rd_v}, {1'b1, 32'h0000_0000});
		pstrb <= 4'h4;
		apb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
		pstrb <= 4'hF;
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk(rd_v, 32'h0037_FFFF);
		setc(cw(8'h40, 8'h20, 3'h0, 2'h0, 1'b0, 1'b0));
		for (int i = 0; i < 4; i++) begin
			shot(tv[i], tv[i]);
			repeat (2) @(posedge pclk);
			#1;
			chk(ovr_flags, te[i]);
			repeat (12) @(posedge pclk);
		end
		for (int s = 0; s < 8; s++) begin
			setc(cw(8'hFF, 8'h80, s[2:0], 2'h0, 1'b0, 1'b0));
			if (s == 0) begin
				shot(12'h800, 12'h800);
				repeat (5) @(posedge pclk);
			end
			shot(12'h800, 12'h800);
			n = 0;
			#1;
			while (ovr_flags.a_high === 1'b1 && n < 2000) begin
				@(posedge pclk);
				#1;
				n++;
			end
			chk(n, HOLD_BASE << s);
		end
		setc(cw(8'h40, 8'h20, 3'h0, 2'h0, 1'b1, 1'b0));
		shot(12'h000, 12'hE00);
		repeat (2) @(posedge pclk);
		#1;
		chk({over_high, over_low}, 2'b11);
		// clock enable low freezes the hold counters
		@(posedge pclk);
		ce <= 1'b0;
		repeat (20) @(posedge pclk);
		#1;
		chk(ovr_flags, 4'hC);
		@(posedge pclk);
		ce <= 1'b1;
		repeat (12) @(posedge pclk);
		apb(1'b1, OFS_INT_STATUS, 32'h0000_000F);
		shot(12'h200, 12'h000);
		repeat (3) @(posedge pclk);
		#1;
		chk(irq, 1'b0);
		apb(1'b0, OFS_INT_STATUS, 32'h0000_0000);
		chk(rd_v, 32'h0000_0003);
		apb(1'b1, OFS_INT_MASK, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		#1;
		chk(irq, 1'b1);
		apb(1'b1, OFS_INT_STATUS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		#1;
		chk({irq, rd_v}, 33'h0);
		apb(1'b0, OFS_INT_STATUS, 32'h0000_0000);
		chk(rd_v, 32'h0000_0002);
		samp_valid <= 1'b1;
		samp <= {12'h000, 12'h1F8};
		for (int i = 0; i < 6; i++) begin
			if (i == 0 || em[i] != em[i-1]) begin
				setc(cw(8'h40, 8'h20, 3'h0, em[i], 1'b0, 1'b0));
				repeat (8) @(posedge pclk);
			end
			word(eq[i], ew[i]);
		end
		@(posedge pclk);
		samp_valid <= 1'b0;
		// complex window of two samples publishes only when complete
		setc(cw(8'h40, 8'h20, 3'h1, 2'h1, 1'b0, 1'b0));
		shot(12'h200, 12'h000);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd_v, 32'h0000_0003);
		shot(12'h000, 12'h000);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd_v, 32'h0000_0033);
		setc(cw(8'h40, 8'h20, 3'h0, 2'h1, 1'b0, 1'b1));
		repeat (12) @(posedge pclk);
		shot(12'h800, 12'h800);
		@(posedge pclk);
		dec_valid <= 1'b1;
		@(posedge pclk);
		dec_valid <= 1'b0;
		#1;
		chk({dec_out_valid, ovr_flags}, 5'h00);
		summarize();
	end
endmodule
`default_nettype wire
